// ===== rtl/bofd_pkg.sv
// Shared constants for the branch-option field decoder.
// Assumes a 32-bit instruction word whose bit 0 (leftmost) is instr[31].
package bofd_pkg;

  localparam int INSTR_W      = 32;
  localparam int DATA_W       = 32;

  // Field positions as lsb index and width within instr[31:0]
  localparam int OPT_LSB      = 21;
  localparam int OPT_W        = 5;
  localparam int SEL_LSB      = 16;
  localparam int SEL_W        = 5;
  localparam int TGT_LSB      = 21;
  localparam int TGT_W        = 5;
  localparam int D_LSB        = 0;
  localparam int D_W          = 16;
  localparam int WOFF_LSB     = 2;
  localparam int WOFF_W       = 14;
  localparam int WOFF_SHIFT   = 2;
  localparam int LXO_LSB      = 1;
  localparam int LXO_W        = 10;
  localparam int SXO_LSB      = 1;
  localparam int SXO_W        = 9;
  localparam int SVCU_LSB     = 12;
  localparam int SVCU_W       = 4;
  localparam int SVCL_LSB     = 2;
  localparam int SVCL_W       = 3;
  localparam int UPM_LSB      = 12;
  localparam int UPM_W        = 8;

  // Condition register layout
  localparam int COND_FIELD_W = 4;
  localparam int COND_FIELDS  = 8;

  // Values after reset
  localparam logic [31:0] COND_RST  = 32'h0000_0000;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;

  // Branch behaviour selected by the options field
  typedef enum logic [3:0] {
    BOFD_DNZ_F  = 4'h0,
    BOFD_DZ_F   = 4'h1,
    BOFD_C_F    = 4'h2,
    BOFD_DNZ_T  = 4'h3,
    BOFD_DZ_T   = 4'h4,
    BOFD_C_T    = 4'h5,
    BOFD_DNZ    = 4'h6,
    BOFD_DZ     = 4'h7,
    BOFD_ALWAYS = 4'h8
  } bofd_mode_t;

  // Whole state of the top module
  typedef struct packed {
    logic [31:0]         cond;
    logic [31:0]         count;
    logic                br_valid;
    logic                br_taken;
    logic                br_dec;
    logic                fld_valid;
    logic [TGT_W-1:0]    tgt;
    logic [31:0]         simm;
    logic [31:0]         disp;
    logic [LXO_W-1:0]    lxo;
    logic [SXO_W-1:0]    sxo;
    logic [SVCU_W-1:0]   svc_up;
    logic [SVCL_W-1:0]   svc_lo;
    logic [UPM_W-1:0]    upm;
  } bofd_state_t;

endpackage : bofd_pkg

// ===== rtl/bofd_sext.sv
// Sign extension of an immediate with optional low-order zero fill.
// Assumes OUT_W exceeds IN_W plus SHIFT; purely combinational.
module bofd_sext #(
  parameter int IN_W  = 16,
  parameter int SHIFT = 0,
  parameter int OUT_W = 32
) (
  input  wire logic [IN_W-1:0]  imm_in,
  output logic      [OUT_W-1:0] imm_out
);

  logic signed [OUT_W-1:0] ext;

  // Sign copies fill upper bits, zeros append on the right
  assign ext     = OUT_W'($signed(imm_in));
  assign imm_out = ext << SHIFT;

endmodule : bofd_sext

// ===== rtl/bofd_cr_field.sv
// One condition-register field with its mask-gated update.
// Assumes the caller holds the register; purely combinational.
module bofd_cr_field #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] old_val,
  input  wire logic [W-1:0] new_val,
  input  wire logic         upd_en,
  output logic      [W-1:0] next_val
);

  assign next_val = upd_en ? new_val : old_val;

endmodule : bofd_cr_field

// ===== rtl/bofd_top.sv
// Branch-option field decoder with loop count and condition registers.
// Assumes same-clock inputs from fetch; bit 0 of the instruction is instr[31].
// Function
// - Options 1x1xx: branch always, no decrement, no condition test.
// - Options 0000x: decrement; branch if count nonzero and condition false.
// - Options 0001x: decrement; branch if count zero and condition false.
// - Options 001xx: no decrement; branch when condition false.
// - Options 0100x: decrement; branch if count nonzero and condition true.
// - Options 0101x: decrement; branch if count zero and condition true.
// - Options 011xx: no decrement; branch when condition true.
// - Options 1x00x: decrement; branch if count nonzero, condition ignored.
// - Options 1x01x: decrement; branch if count zero, condition ignored.
// - Bits 6-10 index the condition bit that receives a result.
// - Bits 16-31 sign-extend to a 32-bit immediate.
// - Bits 16-29 sign-extend with two zero bits appended.
// - Bits 21-30 form the 10-bit long extended opcode.
// - Bits 22-30 form the 9-bit short extended opcode.
// - Supervisor call subfields come from bits 16-19 and 27-29.
// - Bits 12-19 mask which four-bit condition fields get updated.
// - Mask bit 12 enables field 0, through bit 19 for field 7.
// - Bits 11-15 index the condition bit tested by a branch.
module bofd_top (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr,
  input  wire logic        is_cond_branch,
  input  wire logic        is_move_to_cr,
  input  wire logic [31:0] move_data,
  input  wire logic        cond_bit_write_en,
  input  wire logic        cond_bit_value,
  input  wire logic        count_load_en,
  input  wire logic [31:0] count_load_value,
  output logic             branch_valid,
  output logic             branch_taken,
  output logic             count_decremented,
  output logic      [31:0] loop_count_register,
  output logic      [31:0] condition_register,
  output logic             fields_valid,
  output logic      [4:0]  condition_target_bit_field,
  output logic      [31:0] signed_immediate,
  output logic      [31:0] word_offset_displacement,
  output logic      [9:0]  long_extended_opcode_field,
  output logic      [8:0]  short_extended_opcode_field,
  output logic      [3:0]  svc_upper_subfield,
  output logic      [2:0]  svc_lower_subfield,
  output logic      [7:0]  condition_field_update_mask
);

  bofd_pkg::bofd_state_t state_reg;
  bofd_pkg::bofd_state_t state_next;

  logic [bofd_pkg::OPT_W-1:0] branch_options_field;
  logic [bofd_pkg::SEL_W-1:0] condition_bit_select_field;
  logic [bofd_pkg::TGT_W-1:0] tgt_field;
  logic [bofd_pkg::UPM_W-1:0] upm_field;
  logic [31:0]                simm_w;
  logic [31:0]                disp_w;
  logic [31:0]                cond_moved;
  logic [31:0]                count_dec;
  logic                       sel_bit;
  bofd_pkg::bofd_mode_t       mode;
  logic                       dec_en;
  logic                       cond_use;
  logic                       cond_sense;
  logic                       want_zero;
  logic                       count_ok;
  logic                       cond_ok;
  logic                       do_branch;

  // Field slicing
  assign branch_options_field       = instr[bofd_pkg::OPT_LSB +: bofd_pkg::OPT_W];
  assign condition_bit_select_field = instr[bofd_pkg::SEL_LSB +: bofd_pkg::SEL_W];
  assign tgt_field                  = instr[bofd_pkg::TGT_LSB +: bofd_pkg::TGT_W];
  assign upm_field                  = instr[bofd_pkg::UPM_LSB +: bofd_pkg::UPM_W];

  // Tested condition bit, bit 0 is the leftmost
  assign sel_bit   = state_reg.cond[5'd31 - condition_bit_select_field];
  assign count_dec = state_reg.count - 32'h0000_0001;

  // Immediates
  bofd_sext #(
    .IN_W  (bofd_pkg::D_W),
    .SHIFT (0),
    .OUT_W (32)
  ) u_sext_d (
    .imm_in  (instr[bofd_pkg::D_LSB +: bofd_pkg::D_W]),
    .imm_out (simm_w)
  );

  bofd_sext #(
    .IN_W  (bofd_pkg::WOFF_W),
    .SHIFT (bofd_pkg::WOFF_SHIFT),
    .OUT_W (32)
  ) u_sext_woff (
    .imm_in  (instr[bofd_pkg::WOFF_LSB +: bofd_pkg::WOFF_W]),
    .imm_out (disp_w)
  );

  // Mask-gated field update; field k sits in slice 7-k
  genvar gi;
  generate
    for (gi = 0; gi < bofd_pkg::COND_FIELDS; gi++) begin : g_crf
      bofd_cr_field #(
        .W (bofd_pkg::COND_FIELD_W)
      ) u_crf (
        .old_val  (state_reg.cond[gi*bofd_pkg::COND_FIELD_W +: bofd_pkg::COND_FIELD_W]),
        .new_val  (move_data[gi*bofd_pkg::COND_FIELD_W +: bofd_pkg::COND_FIELD_W]),
        .upd_en   (is_move_to_cr && upm_field[gi]),
        .next_val (cond_moved[gi*bofd_pkg::COND_FIELD_W +: bofd_pkg::COND_FIELD_W])
      );
    end
  endgenerate

  // Options pattern to branch behaviour
  always_comb begin
    casez (branch_options_field)
      5'b1?1??: mode = bofd_pkg::BOFD_ALWAYS;
      5'b0000?: mode = bofd_pkg::BOFD_DNZ_F;
      5'b0001?: mode = bofd_pkg::BOFD_DZ_F;
      5'b001??: mode = bofd_pkg::BOFD_C_F;
      5'b0100?: mode = bofd_pkg::BOFD_DNZ_T;
      5'b0101?: mode = bofd_pkg::BOFD_DZ_T;
      5'b011??: mode = bofd_pkg::BOFD_C_T;
      5'b1?00?: mode = bofd_pkg::BOFD_DNZ;
      5'b1?01?: mode = bofd_pkg::BOFD_DZ;
      default:  mode = bofd_pkg::BOFD_ALWAYS;
    endcase
  end

  always_comb begin
    dec_en     = 1'b0;
    cond_use   = 1'b0;
    cond_sense = 1'b0;
    want_zero  = 1'b0;
    case (mode)
      bofd_pkg::BOFD_DNZ_F: begin
        dec_en   = 1'b1;
        cond_use = 1'b1;
      end
      bofd_pkg::BOFD_DZ_F: begin
        dec_en    = 1'b1;
        cond_use  = 1'b1;
        want_zero = 1'b1;
      end
      bofd_pkg::BOFD_C_F: begin
        cond_use = 1'b1;
      end
      bofd_pkg::BOFD_DNZ_T: begin
        dec_en     = 1'b1;
        cond_use   = 1'b1;
        cond_sense = 1'b1;
      end
      bofd_pkg::BOFD_DZ_T: begin
        dec_en     = 1'b1;
        cond_use   = 1'b1;
        cond_sense = 1'b1;
        want_zero  = 1'b1;
      end
      bofd_pkg::BOFD_C_T: begin
        cond_use   = 1'b1;
        cond_sense = 1'b1;
      end
      bofd_pkg::BOFD_DNZ: begin
        dec_en = 1'b1;
      end
      bofd_pkg::BOFD_DZ: begin
        dec_en    = 1'b1;
        want_zero = 1'b1;
      end
      bofd_pkg::BOFD_ALWAYS: begin
        dec_en = 1'b0;
      end
      default: begin
        dec_en = 1'b0;
      end
    endcase
  end

  // Count and condition tests
  assign count_ok  = !dec_en || (want_zero == (count_dec == 32'h0000_0000));
  assign cond_ok   = !cond_use || (sel_bit == cond_sense);
  assign do_branch = instr_valid && is_cond_branch;

  always_comb begin
    state_next          = state_reg;
    state_next.br_valid = do_branch;
    state_next.br_dec   = do_branch && dec_en;
    state_next.br_taken = do_branch && count_ok && cond_ok;
    // Decrement wins over a load in the same cycle
    if (do_branch && dec_en) begin
      state_next.count = count_dec;
    end else if (count_load_en) begin
      state_next.count = count_load_value;
    end
    // Single-bit result write wins over a field move
    state_next.cond = cond_moved;
    if (cond_bit_write_en) begin
      state_next.cond[5'd31 - tgt_field] = cond_bit_value;
    end
    state_next.fld_valid = instr_valid;
    if (instr_valid) begin
      state_next.tgt    = tgt_field;
      state_next.simm   = simm_w;
      state_next.disp   = disp_w;
      state_next.lxo    = instr[bofd_pkg::LXO_LSB +: bofd_pkg::LXO_W];
      state_next.sxo    = instr[bofd_pkg::SXO_LSB +: bofd_pkg::SXO_W];
      state_next.svc_up = instr[bofd_pkg::SVCU_LSB +: bofd_pkg::SVCU_W];
      state_next.svc_lo = instr[bofd_pkg::SVCL_LSB +: bofd_pkg::SVCL_W];
      state_next.upm    = upm_field;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg     <= '0;
      state_reg.cond  <= bofd_pkg::COND_RST;
      state_reg.count <= bofd_pkg::COUNT_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign branch_valid                = state_reg.br_valid;
  assign branch_taken                = state_reg.br_taken;
  assign count_decremented           = state_reg.br_dec;
  assign loop_count_register         = state_reg.count;
  assign condition_register          = state_reg.cond;
  assign fields_valid                = state_reg.fld_valid;
  assign condition_target_bit_field  = state_reg.tgt;
  assign signed_immediate            = state_reg.simm;
  assign word_offset_displacement    = state_reg.disp;
  assign long_extended_opcode_field  = state_reg.lxo;
  assign short_extended_opcode_field = state_reg.sxo;
  assign svc_upper_subfield          = state_reg.svc_up;
  assign svc_lower_subfield          = state_reg.svc_lo;
  assign condition_field_update_mask = state_reg.upm;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic [4:0] opt_c;
  assign opt_c = branch_options_field;

  // A same-cycle load may still change the count; a decrement may not
  property p_always;
    do_branch && opt_c[4] && opt_c[2]
      |=> branch_taken && !count_decremented
          && loop_count_register == ($past(count_load_en) ? $past(count_load_value)
                                                           : $past(loop_count_register));
  endproperty
  a_always: assert property (p_always) else $error("always branch failed");

  property p_dnz_f;
    do_branch && opt_c[4:1] == 4'h0
      |=> branch_taken == (loop_count_register != 32'h0 && !$past(sel_bit));
  endproperty
  a_dnz_f: assert property (p_dnz_f) else $error("0000x decision wrong");

  property p_dz_f;
    do_branch && opt_c[4:1] == 4'h1
      |=> branch_taken == (loop_count_register == 32'h0 && !$past(sel_bit));
  endproperty
  a_dz_f: assert property (p_dz_f) else $error("0001x decision wrong");

  property p_c_f;
    do_branch && opt_c[4:2] == 3'h1
      |=> branch_taken == !$past(sel_bit) && !count_decremented
          && loop_count_register == ($past(count_load_en) ? $past(count_load_value)
                                                           : $past(loop_count_register));
  endproperty
  a_c_f: assert property (p_c_f) else $error("001xx decision wrong");

  property p_dnz_t;
    do_branch && opt_c[4:1] == 4'h4
      |=> branch_taken == (loop_count_register != 32'h0 && $past(sel_bit));
  endproperty
  a_dnz_t: assert property (p_dnz_t) else $error("0100x decision wrong");

  property p_dz_t;
    do_branch && opt_c[4:1] == 4'h5
      |=> branch_taken == (loop_count_register == 32'h0 && $past(sel_bit));
  endproperty
  a_dz_t: assert property (p_dz_t) else $error("0101x decision wrong");

  property p_c_t;
    do_branch && opt_c[4:2] == 3'h3
      |=> branch_taken == $past(sel_bit) && !count_decremented
          && loop_count_register == ($past(count_load_en) ? $past(count_load_value)
                                                           : $past(loop_count_register));
  endproperty
  a_c_t: assert property (p_c_t) else $error("011xx decision wrong");

  property p_dnz;
    do_branch && opt_c[4] && opt_c[2:1] == 2'h0
      |=> branch_taken == (loop_count_register != 32'h0);
  endproperty
  a_dnz: assert property (p_dnz) else $error("1x00x decision wrong");

  property p_dz;
    do_branch && opt_c[4] && opt_c[2:1] == 2'h1
      |=> branch_taken == (loop_count_register == 32'h0);
  endproperty
  a_dz: assert property (p_dz) else $error("1x01x decision wrong");

  property p_dec_wb;
    do_branch && !opt_c[2]
      |=> count_decremented
          && loop_count_register == $past(loop_count_register) - 32'h1;
  endproperty
  a_dec_wb: assert property (p_dec_wb) else $error("count not written back");

  property p_bit_write;
    cond_bit_write_en
      |=> condition_register[5'd31 - $past(tgt_field)] == $past(cond_bit_value);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("target bit not written");

  property p_imm;
    instr_valid
      |=> signed_immediate == {{16{$past(instr[15])}}, $past(instr[15:0])}
          && word_offset_displacement
             == {{16{$past(instr[15])}}, $past(instr[15:2]), 2'b00};
  endproperty
  a_imm: assert property (p_imm) else $error("immediate extension wrong");

  property p_opc;
    instr_valid
      |=> long_extended_opcode_field == $past(instr[10:1])
          && short_extended_opcode_field == $past(instr[9:1])
          && svc_upper_subfield == $past(instr[15:12])
          && svc_lower_subfield == $past(instr[4:2]);
  endproperty
  a_opc: assert property (p_opc) else $error("opcode or subfield wrong");

  property p_field0;
    is_move_to_cr && !cond_bit_write_en
      |=> condition_register[31:28]
          == ($past(instr[19]) ? $past(move_data[31:28])
                               : $past(condition_register[31:28]));
  endproperty
  a_field0: assert property (p_field0) else $error("field 0 mask update wrong");

  c_taken_dec: cover property (do_branch && !opt_c[2] ##1 branch_taken);
  c_not_taken: cover property (do_branch ##1 !branch_taken);
  c_always:    cover property (do_branch && opt_c[4] && opt_c[2]);
  c_move:      cover property (is_move_to_cr && upm_field == 8'hFF);

endmodule : bofd_top

// ===== verif/bofd_fetch_model.sv
// Fetch and branch-side model that drives every input of the decoder except sys_clk and reset.
// Assumes the bench pulses req_go for one cycle per request, same clock.
module bofd_fetch_model (
  input  wire logic        sys_clk,
  input  wire logic        req_go,
  input  wire logic [31:0] req_instr,
  input  wire logic        req_valid,
  input  wire logic        req_branch,
  input  wire logic        req_move,
  input  wire logic [31:0] req_mdata,
  input  wire logic        req_bitwr,
  input  wire logic        req_bitval,
  input  wire logic        req_load,
  input  wire logic [31:0] req_lval,
  output logic             instr_valid,
  output logic      [31:0] instr,
  output logic             is_cond_branch,
  output logic             is_move_to_cr,
  output logic      [31:0] move_data,
  output logic             cond_bit_write_en,
  output logic             cond_bit_value,
  output logic             count_load_en,
  output logic      [31:0] count_load_value
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    instr_valid      = 1'b0;
    instr            = 32'h0000_0000;
    is_cond_branch   = 1'b0;
    is_move_to_cr    = 1'b0;
    move_data        = 32'h0000_0000;
    cond_bit_write_en = 1'b0;
    cond_bit_value   = 1'b0;
    count_load_en    = 1'b0;
    count_load_value = 32'h0000_0000;
  end

  // One cycle per request; idle strobes drop low, idle data lines show the inverse of their last value
  always @(posedge sys_clk) begin
    instr_valid     <= req_go && req_valid;
    is_cond_branch  <= req_go && req_branch;
    is_move_to_cr   <= req_go && req_move;
    cond_bit_write_en <= req_go && req_bitwr;
    count_load_en   <= req_go && req_load;
    if (req_go) begin
      instr            <= req_instr;
      move_data        <= req_mdata;
      cond_bit_value   <= req_bitval;
      count_load_value <= req_lval;
    end else begin
      instr            <= ~instr;
      move_data        <= ~move_data;
      cond_bit_value   <= ~cond_bit_value;
      count_load_value <= ~count_load_value;
    end
  end
endmodule : bofd_fetch_model

// ===== verif/bofd_top_test.sv
// Self-checking bench for the branch-option field decoder.
// Assumes the fetch model above; expectations come from a bench-side model.
module bofd_top_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        req_go  = 1'b0;
  logic [31:0] req_instr = 32'h0000_0000;
  logic        req_valid = 1'b0;
  logic        req_branch = 1'b0;
  logic        req_move = 1'b0;
  logic [31:0] req_mdata = 32'h0000_0000;
  logic        req_bitwr = 1'b0;
  logic        req_bitval = 1'b0;
  logic        req_load = 1'b0;
  logic [31:0] req_lval = 32'h0000_0000;
  logic        instr_valid, is_cond_branch, is_move_to_cr, cond_bit_write_en, cond_bit_value;
  logic        count_load_en, branch_valid, branch_taken, count_decremented, fields_valid;
  logic [31:0] instr, move_data, count_load_value, loop_count_register, condition_register;
  logic [31:0] signed_immediate, word_offset_displacement;
  logic [4:0]  condition_target_bit_field;
  logic [9:0]  long_extended_opcode_field;
  logic [8:0]  short_extended_opcode_field;
  logic [3:0]  svc_upper_subfield;
  logic [2:0]  svc_lower_subfield;
  logic [7:0]  condition_field_update_mask;
  logic [31:0] e_cond = 32'h0000_0000;
  logic [31:0] e_cnt = 32'h0000_0000;
  logic [31:0] e_in = 32'h0000_0000;
  int          bad_count = 0;
  int          n_tests = 0;

  always #50 sys_clk = ~sys_clk;

  bofd_fetch_model bofd_fetch_model_i (.sys_clk(sys_clk), .req_go(req_go),
    .req_instr(req_instr), .req_valid(req_valid), .req_branch(req_branch),
    .req_move(req_move), .req_mdata(req_mdata), .req_bitwr(req_bitwr),
    .req_bitval(req_bitval), .req_load(req_load), .req_lval(req_lval),
    .instr_valid(instr_valid), .instr(instr), .is_cond_branch(is_cond_branch),
    .is_move_to_cr(is_move_to_cr), .move_data(move_data),
    .cond_bit_write_en(cond_bit_write_en), .cond_bit_value(cond_bit_value),
    .count_load_en(count_load_en), .count_load_value(count_load_value));

  bofd_top bofd_top_i (.sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
    .instr(instr), .is_cond_branch(is_cond_branch), .is_move_to_cr(is_move_to_cr),
    .move_data(move_data), .cond_bit_write_en(cond_bit_write_en),
    .cond_bit_value(cond_bit_value), .count_load_en(count_load_en),
    .count_load_value(count_load_value), .branch_valid(branch_valid),
    .branch_taken(branch_taken), .count_decremented(count_decremented),
    .loop_count_register(loop_count_register), .condition_register(condition_register),
    .fields_valid(fields_valid), .condition_target_bit_field(condition_target_bit_field),
    .signed_immediate(signed_immediate), .word_offset_displacement(word_offset_displacement),
    .long_extended_opcode_field(long_extended_opcode_field),
    .short_extended_opcode_field(short_extended_opcode_field),
    .svc_upper_subfield(svc_upper_subfield), .svc_lower_subfield(svc_lower_subfield),
    .condition_field_update_mask(condition_field_update_mask));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // One request through the fetch model, then compare every output
  task automatic op(input logic [31:0] in, input logic v, br, mv, input logic [31:0] md,
                    input logic bw, bv, ld, input logic [31:0] lv);
    logic [4:0] b;
    logic       c;
    logic       tk;
    logic       dc;
    b  = in[25:21];
    c  = e_cond[31 - in[20:16]];
    tk = (b[2] || (b[1] ? (e_cnt - 32'h0000_0001) == 32'h0 : (e_cnt - 32'h0000_0001) != 32'h0))
         && (b[4] || c == b[3]);
    dc = v && br && !b[2];
    if (dc) e_cnt = e_cnt - 32'h0000_0001;
    else if (ld) e_cnt = lv;
    if (mv) for (int j = 0; j < 8; j++) if (in[19-j]) e_cond[31-4*j -: 4] = md[31-4*j -: 4];
    if (bw) e_cond[31 - in[25:21]] = bv;
    if (v) e_in = in;
    @(posedge sys_clk);
    req_instr <= in;
    req_valid <= v;
    req_branch <= br;
    req_move <= mv;
    req_mdata <= md;
    req_bitwr <= bw;
    req_bitval <= bv;
    req_load <= ld;
    req_lval <= lv;
    req_go <= 1'b1;
    @(posedge sys_clk);
    req_go <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(32'(branch_valid), 32'(v && br));
    chk(32'(branch_taken), 32'(v && br && tk));
    chk(32'(count_decremented), 32'(dc));
    chk(loop_count_register, e_cnt);
    chk(condition_register, e_cond);
    chk(32'(fields_valid), 32'(v));
    chk(32'(condition_target_bit_field), 32'(e_in[25:21]));
    chk(signed_immediate, {{16{e_in[15]}}, e_in[15:0]});
    chk(word_offset_displacement, {{16{e_in[15]}}, e_in[15:2], 2'b00});
    chk(32'(long_extended_opcode_field), 32'(e_in[10:1]));
    chk(32'(short_extended_opcode_field), 32'(e_in[9:1]));
    chk(32'({svc_upper_subfield, svc_lower_subfield}), 32'({e_in[15:12], e_in[4:2]}));
    chk(32'(condition_field_update_mask), 32'(e_in[19:12]));
  endtask : op

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(loop_count_register, 32'h0000_0000);
    chk(condition_register, 32'h0000_0000);
    chk(32'({branch_valid, fields_valid}), 32'h0000_0000);
    $display("test reset done");
    // Every options pattern against counts 0, 1, 2 and both condition senses
    for (int p = 0; p < 2; p++) begin
      op(32'h000F_F000, 0, 0, 1, p ? 32'h5A3C_F069 : 32'hA5C3_0F96, 0, 0, 0, 0);
      for (int c = 0; c < 3; c++) begin
        for (int opt = 0; opt < 32; opt++) begin
          op(32'h0000_0000, 0, 0, 0, 0, 0, 0, 1, 32'(c));
          op({6'h10, 5'(opt), 5'(opt * 7 + c + p), 16'(opt * 1297 + c)}, 1, 1, 0, 0, 0, 0,
             1, 32'h0000_0055);
        end
      end
    end
    $display("test branch done");
    op(32'h0000_8004, 1, 0, 0, 0, 0, 0, 0, 0);
    op(32'hFFFF_7FFF, 1, 0, 0, 0, 0, 0, 0, 0);
    op(32'h1234_5678, 0, 1, 0, 0, 0, 0, 0, 0);
    op(32'hA5A5_5A5A, 1, 0, 0, 0, 0, 0, 0, 0);
    $display("test fields done");
    op(32'h000F_F000, 0, 0, 1, 32'h0000_0000, 0, 0, 0, 0);
    for (int j = 0; j < 8; j++) begin
      op({12'h000, 8'(8'h80 >> j), 12'h000}, 0, 0, 1, 32'hFFFF_FFFF, 0, 0, 0, 0);
    end
    op(32'h0000_0000, 0, 0, 1, 32'h0000_0000, 0, 0, 0, 0);
    for (int tb = 0; tb < 32; tb++) begin
      op({6'h00, 5'(tb), 21'h000000}, 0, 0, 0, 0, 1, tb[1], 0, 0);
    end
    op({6'h00, 5'd3, 21'h0F_F000}, 0, 0, 1, 32'h0000_0000, 1, 1, 0, 0);
    $display("test condition done");
    finish_test();
  end
endmodule : bofd_top_test
